/* File: logic/fdcr_pkg.sv */
// Purpose: constants for the floppy controller host register bank
// Assumes: byte-wide host port, offsets relative to the controller base
// Notes:   all widths fixed
package fdcr_pkg;
  // Register offsets
  localparam logic [2:0] FDCR_OFS_RSV0    = 3'h0;
  localparam logic [2:0] FDCR_OFS_RSV1    = 3'h1;
  localparam logic [2:0] FDCR_OFS_DRV_OUT = 3'h2;
  localparam logic [2:0] FDCR_OFS_RSV3    = 3'h3;
  localparam logic [2:0] FDCR_OFS_RATE    = 3'h4;
  localparam logic [2:0] FDCR_OFS_DATA    = 3'h5;
  localparam logic [2:0] FDCR_OFS_RSV6    = 3'h6;
  localparam logic [2:0] FDCR_OFS_CFG     = 3'h7;

  // Drive output control fields
  localparam int FDCR_DOR_MOT_HI  = 5;
  localparam int FDCR_DOR_MOT_LO  = 4;
  localparam int FDCR_DOR_DMAEN   = 3;
  localparam int FDCR_DOR_NRST    = 2;
  localparam int FDCR_DOR_SEL_HI  = 1;
  localparam int FDCR_DOR_SEL_LO  = 0;
  localparam logic [7:0] FDCR_DOR_WMASK = 8'h3F;

  // Rate select fields
  localparam int FDCR_DSR_SRST    = 7;
  localparam int FDCR_DSR_LOWPWR  = 6;
  localparam int FDCR_DSR_PC_HI   = 4;
  localparam int FDCR_DSR_PC_LO   = 2;
  localparam int FDCR_DSR_RATE_HI = 1;
  localparam int FDCR_DSR_RATE_LO = 0;
  localparam logic [7:0] FDCR_DSR_WMASK = 8'h5F;

  // Disk change read
  localparam int FDCR_DIR_CHG     = 7;
  localparam logic [7:0] FDCR_DIR_OE = 8'h80;

  // Reset values
  localparam logic [7:0] FDCR_DOR_RST  = 8'h00;
  localparam logic [7:0] FDCR_DSR_RST  = 8'h00;
  localparam logic [1:0] FDCR_RATE_RST = 2'b10;

  // Timing
  localparam int FDCR_CLK_NS  = 5;
  localparam int FDCR_SRST_NS = 100;
  localparam logic [4:0] FDCR_SRST_CYC = 5'((FDCR_SRST_NS + FDCR_CLK_NS - 1) / FDCR_CLK_NS);

  // Synchronised pin vector width
  localparam int FDCR_SYNC_W = 18;
  // Idle pin levels: select, aen, strobes, change and ack high
  localparam logic [FDCR_SYNC_W-1:0] FDCR_SYNC_RST = 18'h3C006;
endpackage

/* File: logic/fdcr_sync.sv */
// Purpose: two-stage synchroniser for a vector of pins
// Assumes: multi-bit buses are stable around their strobes
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module fdcr_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= rst_val;
      dout   <= rst_val;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

/* File: logic/fdcr_regs.sv */
// Purpose: host register bank of the floppy controller
// Assumes: host strobes and pins are asynchronous to sys_clk
// Notes:   command sequencing lives in the controller core outside
`timescale 1ns/10ps
module fdcr_regs
  import fdcr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] host_addr,
  input  wire logic [7:0] host_data_in,
  input  wire logic       host_ior_n,
  input  wire logic       host_iow_n,
  input  wire logic       host_cs_n,
  input  wire logic       host_aen,
  output logic      [7:0] host_data_out,
  output logic      [7:0] host_data_oe,
  input  wire logic [7:0] core_status,
  input  wire logic [7:0] core_rd_data,
  output logic            core_wr_pulse,
  output logic      [7:0] core_wr_data,
  output logic            core_rd_pulse,
  output logic            core_reset,
  output logic      [1:0] data_rate,
  output logic      [2:0] precomp_sel,
  output logic            low_power,
  output logic      [1:0] drive_sel,
  output logic      [1:0] motor_on_out_n,
  input  wire logic       dma_ack_in_n,
  input  wire logic       tc_in,
  output logic            dma_ack_gated_n,
  output logic            tc_gated,
  input  wire logic       core_drq,
  input  wire logic       core_irq,
  output logic            drq_out,
  output logic            drq_oe,
  output logic            irq_out,
  output logic            irq_oe,
  input  wire logic       disk_swapped_in_n
);
  typedef struct packed {
    logic [7:0] dor;
    logic [7:0] dsr;
    logic [1:0] rate;
    logic [4:0] srst_cnt;
    logic       ctrl_rst;
    logic       iow_d;
    logic       ior_d;
    logic [7:0] dout;
    logic [7:0] doe;
    logic       wr_p;
    logic [7:0] wr_d;
    logic       rd_p;
    logic [1:0] mot_n;
    logic       ack_n;
    logic       tc;
    logic       drq;
    logic       drq_oe;
    logic       irq;
    logic       irq_oe;
  } fdcr_state_t;

  fdcr_state_t st_r, st_nxt;
  logic [FDCR_SYNC_W-1:0] pins_s;
  logic [2:0] addr_s;
  logic [7:0] wdat_s;
  logic cs_n_s, aen_s, ior_n_s, iow_n_s, chg_n_s, ack_n_s, tc_s;
  logic sel, wr_edge, rd_edge, rd_act;

  fdcr_sync #(.W(FDCR_SYNC_W)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .din     ({host_cs_n, host_aen, host_ior_n, host_iow_n, host_addr, host_data_in,
                disk_swapped_in_n, dma_ack_in_n, tc_in}),
    .rst_val (FDCR_SYNC_RST),
    .dout    (pins_s)
  );

  assign {cs_n_s, aen_s, ior_n_s, iow_n_s, addr_s, wdat_s, chg_n_s, ack_n_s, tc_s} = pins_s;
  assign sel     = !cs_n_s && !aen_s;
  assign wr_edge = sel && !iow_n_s && st_r.iow_d;
  assign rd_edge = sel && !ior_n_s && st_r.ior_d;
  assign rd_act  = sel && !ior_n_s;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.iow_d = iow_n_s;
    st_nxt.ior_d = ior_n_s;
    st_nxt.wr_p  = 1'b0;
    st_nxt.rd_p  = 1'b0;
    if (st_r.srst_cnt != 5'h0) begin
      st_nxt.srst_cnt = st_r.srst_cnt - 5'h1;
    end
    if (wr_edge) begin
      if (addr_s == FDCR_OFS_DRV_OUT) begin
        // reset bit stored, no side effects
        st_nxt.dor = wdat_s & FDCR_DOR_WMASK;
      end else if (addr_s == FDCR_OFS_RATE) begin
        // write-only rate register, bit 7 self clears
        st_nxt.dsr  = wdat_s & FDCR_DSR_WMASK;
        st_nxt.rate = wdat_s[FDCR_DSR_RATE_HI:FDCR_DSR_RATE_LO];
        if (wdat_s[FDCR_DSR_SRST]) begin
          st_nxt.srst_cnt = FDCR_SRST_CYC;
          st_nxt.dsr[FDCR_DSR_LOWPWR] = 1'b0;
        end
      end else if (addr_s == FDCR_OFS_DATA) begin
        st_nxt.wr_p = 1'b1;
        st_nxt.wr_d = wdat_s;
        st_nxt.dsr[FDCR_DSR_LOWPWR] = 1'b0;
      end else if (addr_s == FDCR_OFS_CFG) begin
        st_nxt.rate = wdat_s[1:0];
      end
    end
    if (rd_edge && (addr_s == FDCR_OFS_DATA)) begin
      st_nxt.rd_p = 1'b1;
    end
    // Low power exits on any main status or data access
    if (rd_edge && (addr_s == FDCR_OFS_RATE || addr_s == FDCR_OFS_DATA)) begin
      st_nxt.dsr[FDCR_DSR_LOWPWR] = 1'b0;
    end
    // controller reset touches no register here, keep contents
    st_nxt.ctrl_rst = !st_nxt.dor[FDCR_DOR_NRST] || (st_nxt.srst_cnt != 5'h0);
    st_nxt.dout = 8'h00;
    st_nxt.doe  = 8'h00;
    if (rd_act) begin
      if (addr_s == FDCR_OFS_DRV_OUT) begin
        st_nxt.dout = st_r.dor;
        st_nxt.doe  = 8'hFF;
      end else if (addr_s == FDCR_OFS_RATE) begin
        // status read at the rate offset
        st_nxt.dout = core_status;
        st_nxt.doe  = 8'hFF;
      end else if (addr_s == FDCR_OFS_DATA) begin
        st_nxt.dout = core_rd_data;
        st_nxt.doe  = 8'hFF;
      end else if (addr_s == FDCR_OFS_CFG) begin
        st_nxt.dout[FDCR_DIR_CHG] = !chg_n_s;
        st_nxt.doe  = FDCR_DIR_OE;
      end
    end
    st_nxt.mot_n = ~st_nxt.dor[FDCR_DOR_MOT_HI:FDCR_DOR_MOT_LO];
    st_nxt.ack_n  = st_nxt.dor[FDCR_DOR_DMAEN] ? ack_n_s : 1'b1;
    st_nxt.tc     = st_nxt.dor[FDCR_DOR_DMAEN] && tc_s;
    st_nxt.drq    = core_drq;
    st_nxt.irq    = core_irq;
    st_nxt.drq_oe = st_nxt.dor[FDCR_DOR_DMAEN];
    st_nxt.irq_oe = st_nxt.dor[FDCR_DOR_DMAEN];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.dor      <= FDCR_DOR_RST;
      st_r.dsr      <= FDCR_DSR_RST;
      st_r.rate     <= FDCR_RATE_RST;
      st_r.ctrl_rst <= 1'b1;
      st_r.iow_d    <= 1'b1;
      st_r.ior_d    <= 1'b1;
      st_r.mot_n    <= 2'h3;
      st_r.ack_n    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_data_out   = st_r.dout;
  assign host_data_oe    = st_r.doe;
  assign core_wr_pulse   = st_r.wr_p;
  assign core_wr_data    = st_r.wr_d;
  assign core_rd_pulse   = st_r.rd_p;
  assign core_reset      = st_r.ctrl_rst;
  assign data_rate       = st_r.rate;
  // precompensation amount; start track belongs to the core
  assign precomp_sel     = st_r.dsr[FDCR_DSR_PC_HI:FDCR_DSR_PC_LO];
  assign low_power       = st_r.dsr[FDCR_DSR_LOWPWR];
  // encoded drive number, one drive at a time
  assign drive_sel       = st_r.dor[FDCR_DOR_SEL_HI:FDCR_DOR_SEL_LO];
  assign motor_on_out_n  = st_r.mot_n;
  assign dma_ack_gated_n = st_r.ack_n;
  assign tc_gated        = st_r.tc;
  assign drq_out         = st_r.drq;
  assign drq_oe          = st_r.drq_oe;
  assign irq_out         = st_r.irq;
  assign irq_oe          = st_r.irq_oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_motor;
    motor_on_out_n == ~st_r.dor[5:4];
  endproperty
  a_motor: assert property (p_motor) else $error("motor outputs differ from enables");

  property p_dma_gate;
    !st_r.dor[FDCR_DOR_DMAEN] |-> (!drq_oe && !irq_oe && !tc_gated && dma_ack_gated_n);
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma path active while gated");

  property p_nrst_hold;
    (wr_edge && addr_s == FDCR_OFS_DRV_OUT && !wdat_s[2]) |=> core_reset;
  endproperty
  a_nrst_hold: assert property (p_nrst_hold) else $error("reset bit write did not reset");

  property p_rst_keeps_rate;
    (core_reset && !wr_edge) |=> $stable(data_rate) && $stable(precomp_sel);
  endproperty
  a_rst_keeps_rate: assert property (p_rst_keeps_rate) else $error("rate changed by reset");

  property p_dor_kept;
    (!wr_edge) |=> $stable(st_r.dor);
  endproperty
  a_dor_kept: assert property (p_dor_kept) else $error("drive output changed without write");

  property p_status_rd;
    (rd_act && addr_s == FDCR_OFS_RATE) |=> (host_data_out == $past(core_status) && host_data_oe == 8'hFF);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_rate_latest;
    (wr_edge && (addr_s == FDCR_OFS_RATE || addr_s == FDCR_OFS_CFG)) |=> data_rate == $past(wdat_s[1:0]);
  endproperty
  a_rate_latest: assert property (p_rate_latest) else $error("rate not from latest write");

  property p_srst;
    (wr_edge && addr_s == FDCR_OFS_RATE && wdat_s[7]) |=>
      core_reset [*8] ##12 core_reset ##1 (core_reset == !st_r.dor[FDCR_DOR_NRST]);
  endproperty
  a_srst: assert property (p_srst) else $error("software reset pulse wrong");

  property p_dir_rd;
    (rd_act && addr_s == FDCR_OFS_CFG) |=> (host_data_oe == 8'h80 && host_data_out[7] == !$past(chg_n_s));
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("disk change read wrong");

  property p_rsv;
    (addr_s inside {3'h0, 3'h1, 3'h3, 3'h6}) |=> (host_data_oe == 8'h00 && $stable(st_r.dor) && $stable(data_rate));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved offset had effect");

  c_drive2: cover property (wr_edge && addr_s == FDCR_OFS_DRV_OUT && wdat_s == 8'h4E);
  c_srst:   cover property (wr_edge && addr_s == FDCR_OFS_RATE && wdat_s[7]);
  c_ccr:    cover property (wr_edge && addr_s == FDCR_OFS_CFG);
  c_dirrd:  cover property (rd_edge && addr_s == FDCR_OFS_CFG);
endmodule

/* File: bench/fdcr_far_model.sv */
// Purpose: model of the controller core behind the register bank
// Assumes: a data port read returns the last byte written
// Notes:   status is a fixed pattern, arbitrary
`timescale 1ns/10ps
module fdcr_far_model #(
  parameter logic [7:0] STATUS = 8'h80
) (
  input  wire logic       sys_clk,
  input  wire logic       core_wr_pulse,
  input  wire logic [7:0] core_wr_data,
  output logic      [7:0] core_status,
  output logic      [7:0] core_rd_data
);
  assign core_status = STATUS;
  initial core_rd_data = 8'h00;
  // Echo lets a read prove the write reached the core
  always @(posedge sys_clk) begin
    if (core_wr_pulse === 1'h1) begin
      core_rd_data <= core_wr_data;
    end
  end
endmodule

/* File: bench/fdcr_regs_tb.sv */
// Purpose: self-checking bench for the floppy controller register bank
// Assumes: host strobes held 4 clocks, released 4 clocks
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module fdcr_regs_tb;
  import fdcr_pkg::*;
  logic       sys_clk = 1'h0, resetn = 1'h0, host_ior_n = 1'h1, host_iow_n = 1'h1, host_cs_n = 1'h1;
  logic       host_aen = 1'h0, dma_ack_in_n = 1'h1, tc_in = 1'h0, core_drq = 1'h0, core_irq = 1'h0;
  logic       disk_swapped_in_n = 1'h1;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_data_in = 8'h00, host_data_out, host_data_oe, core_status, core_rd_data, core_wr_data;
  logic       core_wr_pulse, core_rd_pulse, core_reset, low_power, dma_ack_gated_n, tc_gated;
  logic       drq_out, drq_oe, irq_out, irq_oe;
  logic [1:0] data_rate, drive_sel, motor_on_out_n;
  logic [2:0] precomp_sel;
  logic [7:0] rd_d, rd_oe;
  logic [7:0] sel_v [4] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F};
  logic [2:0] rsv_v [4] = '{FDCR_OFS_RSV0, FDCR_OFS_RSV1, FDCR_OFS_RSV3, FDCR_OFS_RSV6};
  int         err_total = 0, n_compared = 0, n, n_rd_p = 0;

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (core_rd_pulse === 1'h1) begin
      n_rd_p++;
    end
  end

  fdcr_regs i_dut (.sys_clk(sys_clk), .resetn(resetn), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .host_cs_n(host_cs_n), .host_aen(host_aen),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .core_status(core_status),
    .core_rd_data(core_rd_data), .core_wr_pulse(core_wr_pulse), .core_wr_data(core_wr_data),
    .core_rd_pulse(core_rd_pulse), .core_reset(core_reset), .data_rate(data_rate), .precomp_sel(precomp_sel),
    .low_power(low_power), .drive_sel(drive_sel), .motor_on_out_n(motor_on_out_n),
    .dma_ack_in_n(dma_ack_in_n), .tc_in(tc_in), .dma_ack_gated_n(dma_ack_gated_n), .tc_gated(tc_gated),
    .core_drq(core_drq), .core_irq(core_irq), .drq_out(drq_out), .drq_oe(drq_oe), .irq_out(irq_out),
    .irq_oe(irq_oe), .disk_swapped_in_n(disk_swapped_in_n));

  fdcr_far_model i_far (.sys_clk(sys_clk), .core_wr_pulse(core_wr_pulse), .core_wr_data(core_wr_data),
    .core_status(core_status), .core_rd_data(core_rd_data));

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_addr = a;
    host_data_in = d;
    host_cs_n = 1'h0;
    host_iow_n = 1'h0;
    tick(4);
    host_iow_n = 1'h1;
    tick(4);
    host_cs_n = 1'h1;
    tick(1);
  endtask

  task automatic rd(input logic [2:0] a);
    host_addr = a;
    host_cs_n = 1'h0;
    host_ior_n = 1'h0;
    tick(4);
    rd_d = host_data_out;
    rd_oe = host_data_oe;
    host_ior_n = 1'h1;
    tick(4);
    host_cs_n = 1'h1;
    tick(1);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    // Synchronisers load idle levels at the first reset edge
    tick(2);
    resetn = 1'h1;
    tick(2);
    chk({6'h00, motor_on_out_n}, 8'h03);
    chk({7'h00, core_reset}, 8'h01);
    chk({6'h00, data_rate}, {6'h00, FDCR_RATE_RST});
    rd(FDCR_OFS_DRV_OUT);
    chk(rd_d, FDCR_DOR_RST);
    $display("Test reset finished");
    for (int i = 0; i < 4; i++) begin
      wr(FDCR_OFS_DRV_OUT, sel_v[i]);
      chk({6'h00, drive_sel}, 8'(i));
      chk({6'h00, motor_on_out_n}, {6'h00, ~sel_v[i][5:4]});
      chk({7'h00, core_reset}, 8'h00);
      rd(FDCR_OFS_DRV_OUT);
      chk(rd_d, sel_v[i] & FDCR_DOR_WMASK);
    end
    $display("Test drive select finished");
    core_drq = 1'h1;
    core_irq = 1'h1;
    dma_ack_in_n = 1'h0;
    tc_in = 1'h1;
    wr(FDCR_OFS_DRV_OUT, 8'h04);
    chk({4'h0, drq_oe, irq_oe, dma_ack_gated_n, tc_gated}, 8'h02);
    wr(FDCR_OFS_DRV_OUT, 8'h0C);
    chk({4'h0, drq_oe, irq_oe, dma_ack_gated_n, tc_gated}, 8'h0D);
    chk({6'h00, drq_out, irq_out}, 8'h03);
    dma_ack_in_n = 1'h1;
    tc_in = 1'h0;
    $display("Test dma gate finished");
    wr(FDCR_OFS_RATE, 8'h5D);
    chk({3'h0, precomp_sel, data_rate}, 8'h1D);
    chk({7'h00, low_power}, 8'h01);
    rd(FDCR_OFS_RATE);
    chk(rd_d, 8'h80);
    chk(rd_oe, 8'hFF);
    chk({7'h00, low_power}, 8'h00);
    wr(FDCR_OFS_CFG, 8'h03);
    chk({6'h00, data_rate}, 8'h03);
    wr(FDCR_OFS_DRV_OUT, 8'h08);
    chk({7'h00, core_reset}, 8'h01);
    chk({3'h0, precomp_sel, data_rate}, 8'h1F);
    tick(FDCR_SRST_CYC);
    wr(FDCR_OFS_DRV_OUT, 8'h0C);
    disk_swapped_in_n = 1'h0;
    rd(FDCR_OFS_CFG);
    chk(rd_oe, FDCR_DIR_OE);
    chk({7'h00, rd_d[7]}, 8'h01);
    $display("Test rate finished");
    wr(FDCR_OFS_RATE, 8'h9D);
    chk({7'h00, core_reset}, 8'h01);
    n = 0;
    while (core_reset !== 1'h0 && n < 40) begin
      tick(1);
      n++;
    end
    // Take edge is 3 clocks into the write, which spends 9
    chk(8'(n), 8'(FDCR_SRST_CYC - 6));
    if (n >= 40) begin
      end_sim();
    end
    chk({3'h0, precomp_sel, data_rate}, 8'h1D);
    rd(FDCR_OFS_DRV_OUT);
    chk(rd_d, 8'h0C);
    $display("Test soft reset finished");
    wr(FDCR_OFS_DATA, 8'hA5);
    rd(FDCR_OFS_DATA);
    chk(rd_d, 8'hA5);
    chk(8'(n_rd_p), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(rsv_v[i], 8'hFF);
      rd(rsv_v[i]);
      chk(rd_oe, 8'h00);
    end
    host_aen = 1'h1;
    wr(FDCR_OFS_DRV_OUT, 8'h00);
    host_aen = 1'h0;
    rd(FDCR_OFS_DRV_OUT);
    chk(rd_d, 8'h0C);
    chk({6'h00, data_rate}, 8'h01);
    $display("Test reserved finished");
    resetn = 1'h0;
    tick(2);
    resetn = 1'h1;
    tick(2);
    chk({3'h0, precomp_sel, data_rate}, {6'h00, FDCR_RATE_RST});
    chk({7'h00, core_reset}, 8'h01);
    rd(FDCR_OFS_DRV_OUT);
    chk(rd_d, FDCR_DOR_RST);
    $display("Test mid reset finished");
    end_sim();
  end
endmodule
